// >>> hdl/udc_ctrl_status.v
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "udc_consts.vh"

module udc_ctrl_status
(
	// Clock and reset
	input  wire        clock,
	input  wire        rst_n,
	// Register port
	input  wire [15:0] reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata_q,
	// Link side events
	input  wire        link_suspended,
	input  wire        iso_err_evt,
	input  wire [3:0]  iso_err_ep,
	input  wire        remote_wakeup_en,
	input  wire        module_enable,
	// Protected bit updates from the core
	input  wire        prot_upd_req,
	output reg         prot_upd_go_q,
	// FIFO RAM arbitration
	input  wire        usb_fifo_busy,
	input  wire        app_fifo_req,
	output reg         app_fifo_stall_q,
	output reg         fifo_ram_half_split_q,
	// Module reset and resume
	output reg         module_hard_reset_q,
	output reg         resume_start_q,
	// Responder IN data phase
	input  wire        in_byte_ready,
	output reg         in_byte_valid_q,
	output reg  [7:0]  in_byte_q
);

	// ==========================================================
	// Link input synchronisers
	reg        link_suspended_s1_q;           // First stage, read by second only
	reg        link_suspended_s2_q;           // Synchronised suspend level
	reg        rwu_s1_q;            // First stage
	reg        rwu_s2_q;            // Synchronised wakeup enable

	// ==========================================================
	// Control and status state
	reg [3:0]  iso_error_endpoint_number_q; // Last iso error endpoint
	reg        iso_error_flag_q;            // Sticky iso error flag
	reg        descriptor_ram_owner_select_q; // 1: controller owns RAM
	reg        rmw_lock_q;                  // Read-modify-write lock
	reg        upd_pending_q;               // Held protected update
	reg [3:0]  hrst_cnt_q;                  // Hard reset stretch count
	reg [10:0] descriptor_length_q;         // Bytes to send
	reg [9:0]  descriptor_address_q;        // RAM offset
	reg        responder_busy_q;            // Responder sending
	reg [10:0] remain_q;                    // Bytes left to send
	reg        fetch_q;                     // RAM read issued last cycle
	reg [31:0] rdata_d;                     // Read mux

	// Descriptor RAM wiring
	wire [7:0] ram_rdata;
	wire       sw_access;
	wire       sw_wr_data;
	wire       sw_rd_data;
	wire       upd_now;

	// Decode a strobe at one offset
	function hit;
		input [15:0] a;
		input [15:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// Software may touch the RAM only when it owns it and module is off
	assign sw_access  = ~descriptor_ram_owner_select_q & ~module_enable;
	assign sw_wr_data = reg_wr & hit(reg_addr, `UDC_OFF_DRAM_DATA) & sw_access;
	assign sw_rd_data = reg_rd & hit(reg_addr, `UDC_OFF_DRAM_DATA) & sw_access;
	// Protected update goes now only when unlocked
	assign upd_now    = (prot_upd_req | upd_pending_q) & ~rmw_lock_q;

	// ==========================================================
	// Descriptor RAM instance
	udc_desc_ram u_ram
	(
		.clock     (clock),
		.wr_en     (sw_wr_data),
		.wr_addr   (descriptor_address_q),
		.wr_data   (reg_wdata[7:0]),
		.rd_addr   (descriptor_address_q),
		.rd_data_q (ram_rdata)
	);

	// ==========================================================
	// Synchronise link levels
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_suspended_s1_q <= 1'b0;
			link_suspended_s2_q <= 1'b0;
			rwu_s1_q  <= 1'b0;
			rwu_s2_q  <= 1'b0;
		end
		else
		begin
			link_suspended_s1_q <= link_suspended;
			link_suspended_s2_q <= link_suspended_s1_q;
			rwu_s1_q  <= remote_wakeup_en;
			rwu_s2_q  <= rwu_s1_q;
		end
	end

	// ==========================================================
	// Control register, iso error capture, lock and hard reset
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fifo_ram_half_split_q         <= 1'b0;
			descriptor_ram_owner_select_q <= 1'b0;
			rmw_lock_q                    <= 1'b0;
			hrst_cnt_q                    <= 4'h0;
			module_hard_reset_q           <= 1'b0;
			resume_start_q                <= 1'b0;
			iso_error_endpoint_number_q   <= 4'h0;
			iso_error_flag_q              <= 1'b0;
			upd_pending_q                 <= 1'b0;
			prot_upd_go_q                 <= 1'b0;
			app_fifo_stall_q              <= 1'b0;
		end
		else
		begin
			// Resume pulse is one cycle; register reads back zero
			resume_start_q <= 1'b0;
			if (reg_wr && hit(reg_addr, `UDC_OFF_CONTROL))
			begin
				fifo_ram_half_split_q         <= reg_wdata[`UDC_CR_SPLIT_BIT];
				descriptor_ram_owner_select_q <= reg_wdata[`UDC_CR_OWNER_BIT];
				rmw_lock_q                    <= reg_wdata[`UDC_CR_LOCK_BIT];
				if (reg_wdata[`UDC_CR_HRST_BIT])
				begin
					hrst_cnt_q <= `UDC_HRST_CYCLES;
				end
				else if (hrst_cnt_q != 4'h0)
				begin
					// Other control writes must not stretch the reset
					hrst_cnt_q <= hrst_cnt_q - 4'h1;
				end
				// Only a written one with wakeup enabled starts resume
				resume_start_q <= reg_wdata[`UDC_CR_RESUME_BIT] & rwu_s2_q;
			end
			else if (hrst_cnt_q != 4'h0)
			begin
				hrst_cnt_q <= hrst_cnt_q - 4'h1;
			end
			module_hard_reset_q <= (hrst_cnt_q != 4'h0);

			// Endpoint number kept across flag clear
			if (iso_err_evt)
			begin
				iso_error_endpoint_number_q <= iso_err_ep;
			end
			// Sticky flag: event wins over write-one clear
			if (iso_err_evt)
			begin
				iso_error_flag_q <= 1'b1;
			end
			else if (reg_wr && hit(reg_addr, `UDC_OFF_INT_STATUS)
				&& reg_wdata[`UDC_IS_ISO_ERROR_FLAG_BIT])
			begin
				iso_error_flag_q <= 1'b0;
			end

			// Hold protected updates while locked, release after
			prot_upd_go_q <= upd_now;
			if (upd_now)
			begin
				upd_pending_q <= 1'b0;
			end
			else if (prot_upd_req)
			begin
				upd_pending_q <= 1'b1;
			end

			// Stall application only in shared mode with USB active
			app_fifo_stall_q <= app_fifo_req & usb_fifo_busy & ~fifo_ram_half_split_q;
		end
	end

	// ==========================================================
	// Descriptor control, data access and responder
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			descriptor_length_q  <= 11'h000;
			descriptor_address_q <= 10'h000;
			responder_busy_q     <= 1'b0;
			remain_q             <= 11'h000;
			fetch_q              <= 1'b0;
			in_byte_valid_q      <= 1'b0;
			in_byte_q            <= 8'h00;
		end
		else if (!responder_busy_q)
		begin
			in_byte_valid_q <= 1'b0;
			fetch_q         <= 1'b0;
			if (reg_wr && hit(reg_addr, `UDC_OFF_DRAM_CTRL))
			begin
				descriptor_length_q  <= reg_wdata[`UDC_DC_LEN_MSB:`UDC_DC_LEN_LSB];
				descriptor_address_q <= reg_wdata[`UDC_DC_ADDR_MSB:0];
				// Launch only in controller mode with a nonzero length
				if (reg_wdata[`UDC_DC_START_BIT] && descriptor_ram_owner_select_q
					&& (reg_wdata[`UDC_DC_LEN_MSB:`UDC_DC_LEN_LSB] != 11'h000))
				begin
					responder_busy_q <= 1'b1;
					remain_q <= reg_wdata[`UDC_DC_LEN_MSB:`UDC_DC_LEN_LSB];
				end
			end
			else if (sw_wr_data || sw_rd_data)
			begin
				descriptor_address_q <= descriptor_address_q + 10'h001;
			end
		end
		else
		begin
			// Sending: fetch at address, present byte, wait for take
			if (in_byte_valid_q)
			begin
				if (in_byte_ready)
				begin
					in_byte_valid_q <= 1'b0;
					if (remain_q == 11'h001)
					begin
						responder_busy_q <= 1'b0;
					end
					remain_q <= remain_q - 11'h001;
				end
			end
			else if (fetch_q)
			begin
				fetch_q              <= 1'b0;
				in_byte_valid_q      <= 1'b1;
				in_byte_q            <= ram_rdata;
				descriptor_address_q <= descriptor_address_q + 10'h001;
			end
			else
			begin
				fetch_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Read data mux
	always @*
	begin
		rdata_d = 32'h0000_0000;
		if (hit(reg_addr, `UDC_OFF_STATUS))
		begin
			rdata_d[`UDC_SR_LINK_SUSPENDED_BIT]     = link_suspended_s2_q;
			rdata_d[`UDC_SR_ISOEP_MSB:0]  = iso_error_endpoint_number_q;
		end
		else if (hit(reg_addr, `UDC_OFF_CONTROL))
		begin
			rdata_d[`UDC_CR_SPLIT_BIT] = fifo_ram_half_split_q;
			rdata_d[`UDC_CR_OWNER_BIT] = descriptor_ram_owner_select_q;
			rdata_d[`UDC_CR_HRST_BIT]  = module_hard_reset_q;
			rdata_d[`UDC_CR_LOCK_BIT]  = rmw_lock_q;
		end
		else if (hit(reg_addr, `UDC_OFF_DRAM_CTRL))
		begin
			rdata_d[`UDC_DC_BUSY_BIT] = responder_busy_q;
			rdata_d[`UDC_DC_LEN_MSB:`UDC_DC_LEN_LSB] = descriptor_length_q;
			rdata_d[`UDC_DC_ADDR_MSB:0] = descriptor_address_q;
		end
		else if (hit(reg_addr, `UDC_OFF_INT_STATUS))
		begin
			rdata_d[`UDC_IS_ISO_ERROR_FLAG_BIT] = iso_error_flag_q;
		end
		else
		begin
			rdata_d = 32'h0000_0000;
		end
	end

	// ==========================================================
	// Registered read data; status writes simply have no target
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata_q <= 32'h0000_0000;
		end
		else if (sw_rd_data)
		begin
			// Descriptor byte from the addressed RAM location
			reg_rdata_q <= {24'h000000, ram_rdata};
		end
		else if (reg_rd && hit(reg_addr, `UDC_OFF_DRAM_DATA))
		begin
			// Refused data read answers zero
			reg_rdata_q <= 32'h0000_0000;
		end
		else if (reg_rd)
		begin
			reg_rdata_q <= rdata_d;
		end
		else
		begin
			reg_rdata_q <= 32'h0000_0000;
		end
	end

endmodule // udc_ctrl_status

// >>> hdl/udc_consts.vh
`ifndef UDC_CONSTS_VH
`define UDC_CONSTS_VH

// ==========================================================
// Register byte offsets
`define UDC_OFF_STATUS      16'hB400
`define UDC_OFF_CONTROL     16'hB404
`define UDC_OFF_DRAM_CTRL   16'hB408
`define UDC_OFF_DRAM_DATA   16'hB40C
`define UDC_OFF_INT_STATUS  16'hB410

// ==========================================================
// Status register fields
`define UDC_SR_LINK_SUSPENDED_BIT     7
`define UDC_SR_ISOEP_MSB    3

// ==========================================================
// Control register fields
`define UDC_CR_SPLIT_BIT    5
`define UDC_CR_OWNER_BIT    3
`define UDC_CR_HRST_BIT     2
`define UDC_CR_LOCK_BIT     1
`define UDC_CR_RESUME_BIT   0

// ==========================================================
// Descriptor control fields
`define UDC_DC_START_BIT    31
`define UDC_DC_BUSY_BIT     30
`define UDC_DC_LEN_MSB      26
`define UDC_DC_LEN_LSB      16
`define UDC_DC_ADDR_MSB     9

// ==========================================================
// Interrupt status fields and geometry
`define UDC_IS_ISO_ERROR_FLAG_BIT   0
`define UDC_RAM_DEPTH       1024
`define UDC_HRST_CYCLES     4'h8

`endif

// >>> hdl/udc_desc_ram.v
`timescale 1ns/1ps

// ==========================================================
// Descriptor RAM: 1024 bytes of flip-flops, one write, one read port
module udc_desc_ram
(
	// Clock
	input  wire       clock,
	// Write port
	input  wire       wr_en,
	input  wire [9:0] wr_addr,
	input  wire [7:0] wr_data,
	// Read port, shows the addressed byte in the same cycle
	input  wire [9:0] rd_addr,
	output reg  [7:0] rd_data_q
);

	// Storage array
	reg [7:0] mem_q [0:1023];

	// Clocked write
	always @(posedge clock)
	begin
		if (wr_en)
		begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// Plain indexed read, so a read straight after a write or an
	// address step never sees a stale byte
	always @*
	begin
		rd_data_q = mem_q[rd_addr];
	end

endmodule // udc_desc_ram

// >>> sim/udc_monitor.sv
`timescale 1ns/1ps
`include "udc_consts.vh"

// ==========================================
// Port checker
module udc_monitor
(
	// Clock and reset
	input wire        clock,
	input wire        rst_n,
	// Register writes
	input wire [15:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	// Core side
	input wire        prot_upd_req,
	input wire        prot_upd_go_q,
	input wire        usb_fifo_busy,
	input wire        app_fifo_req,
	input wire        app_fifo_stall_q,
	input wire        fifo_ram_half_split_q,
	input wire        module_hard_reset_q,
	input wire        resume_start_q,
	input wire        in_byte_ready,
	input wire        in_byte_valid_q,
	input wire [7:0]  in_byte_q
);
	wire ctl_wr = reg_wr && reg_addr == `UDC_OFF_CONTROL; // Control write
	reg  lock_q;                                           // Lock mirror
	reg  pend_q;                                           // Held update

	// Track the lock and any update held behind it
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lock_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else
		begin
			if (ctl_wr)
				lock_q <= reg_wdata[1];
			if (prot_upd_go_q)
				pend_q <= 1'b0;
			else if (prot_upd_req && lock_q)
				pend_q <= 1'b1;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_hrst_hold; module_hard_reset_q [*8]; endsequence
	sequence s_hrst_end; !module_hard_reset_q; endsequence

	property p_res; resume_start_q |=> !resume_start_q; endproperty
	property p_hrst; $rose(module_hard_reset_q) |-> s_hrst_hold ##1 s_hrst_end; endproperty
	property p_stl;
		app_fifo_req && usb_fifo_busy && !fifo_ram_half_split_q |=> app_fifo_stall_q;
	endproperty
	property p_spl; fifo_ram_half_split_q |=> !app_fifo_stall_q; endproperty
	property p_swr; ctl_wr |=> fifo_ram_half_split_q == $past(reg_wdata[5]); endproperty
	property p_lck; $past(lock_q) |-> !prot_upd_go_q; endproperty
	property p_pnd; $fell(lock_q) && pend_q |-> ##[1:4] prot_upd_go_q; endproperty
	property p_inh;
		in_byte_valid_q && !in_byte_ready |=> in_byte_valid_q && $stable(in_byte_q);
	endproperty

	a_res: assert property (p_res) else $error("resume pulse too long");
	a_hrst: assert property (p_hrst) else $error("hard reset length");
	a_stl: assert property (p_stl) else $error("no stall when shared");
	a_spl: assert property (p_spl) else $error("stall while split");
	a_swr: assert property (p_swr) else $error("split bit wrong");
	a_lck: assert property (p_lck) else $error("update while locked");
	a_pnd: assert property (p_pnd) else $error("held update lost");
	a_inh: assert property (p_inh) else $error("in byte not held");
endmodule // udc_monitor

// >>> sim/udc_host_model.sv
`timescale 1ns/1ps

// ==========================================
// Host taking IN data bytes
module udc_host_model
(
	// Clock and reset
	input  wire       clock,
	input  wire       rst_n,
	// IN data phase
	input  wire       in_byte_valid_q,
	input  wire [7:0] in_byte_q,
	input  wire       slow,
	output reg        in_byte_ready
);
	reg [7:0] got [0:15]; // Bytes taken
	int       cnt;        // Byte count
	reg [1:0] ph;         // Slow pacing phase

	// Slow mode accepts one cycle in four
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_byte_ready <= 1'b0;
			ph <= 2'h0;
			cnt <= 0;
		end
		else
		begin
			ph <= ph + 2'h1;
			in_byte_ready <= !slow || ph == 2'h0;
			if (in_byte_valid_q && in_byte_ready)
			begin
				got[cnt[3:0]] <= in_byte_q;
				cnt <= cnt + 1;
			end
		end
	end
endmodule // udc_host_model

// >>> sim/usb_device_ctrl_status_descriptor_ram_tb_top.sv
`timescale 1ns/1ps
`include "udc_consts.vh"

// ==========================================
// Testbench
module usb_device_ctrl_status_descriptor_ram_tb_top;
	reg clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	reg [15:0] reg_addr = 16'h0;
	reg [31:0] reg_wdata = 32'h0;
	reg link_suspended = 1'b0, iso_err_evt = 1'b0, remote_wakeup_en = 1'b1;
	reg [3:0] iso_err_ep = 4'h0;
	reg module_enable = 1'b0, prot_upd_req = 1'b0, usb_fifo_busy = 1'b0;
	reg app_fifo_req = 1'b0, slow = 1'b1;
	wire [31:0] reg_rdata_q;
	wire prot_upd_go_q, app_fifo_stall_q, fifo_ram_half_split_q;
	wire module_hard_reset_q, resume_start_q, in_byte_ready, in_byte_valid_q;
	wire [7:0] in_byte_q;
	wire [2:0] sigs = {module_hard_reset_q, resume_start_q, prot_upd_go_q};
	int bad_count = 0, samples_checked = 0;
	logic [31:0] v;
	int n;

	initial forever #2.5 clock = ~clock;

	udc_ctrl_status uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.link_suspended(link_suspended), .iso_err_evt(iso_err_evt), .iso_err_ep(iso_err_ep),
		.remote_wakeup_en(remote_wakeup_en), .module_enable(module_enable),
		.prot_upd_req(prot_upd_req), .prot_upd_go_q(prot_upd_go_q),
		.usb_fifo_busy(usb_fifo_busy), .app_fifo_req(app_fifo_req),
		.app_fifo_stall_q(app_fifo_stall_q), .fifo_ram_half_split_q(fifo_ram_half_split_q),
		.module_hard_reset_q(module_hard_reset_q), .resume_start_q(resume_start_q),
		.in_byte_ready(in_byte_ready), .in_byte_valid_q(in_byte_valid_q), .in_byte_q(in_byte_q));
	udc_host_model host (.clock(clock), .rst_n(rst_n), .in_byte_valid_q(in_byte_valid_q),
		.in_byte_q(in_byte_q), .slow(slow), .in_byte_ready(in_byte_ready));

	// ==========================================
	// Bus and check helpers
	task wr(input [15:0] a, input [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input [15:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e)
		begin
			$display("CHECK FAILED %0t %s", $time, m);
			bad_count++;
		end
	endtask
	task cnt(input int i, output int k);
		k = 0;
		repeat (12)
		begin
			#1 k += (sigs[i] === 1'b1);
			@(posedge clock);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================
	// Scenarios
	task t_status;
		rd(`UDC_OFF_STATUS, v);
		chk(v, 32'h0, "status reset");
		link_suspended <= 1'b1;
		repeat (4) @(posedge clock);
		wr(`UDC_OFF_STATUS, 32'hFFFFFFFF);
		rd(`UDC_OFF_STATUS, v);
		chk(v, 32'h80, "status suspend");
		link_suspended <= 1'b0;
	endtask
	task t_iso;
		iso_err_ep <= 4'h5;
		iso_err_evt <= 1'b1;
		@(posedge clock);
		iso_err_evt <= 1'b0;
		repeat (4) @(posedge clock);
		rd(`UDC_OFF_INT_STATUS, v);
		chk(v[0], 1'b1, "iso flag");
		wr(`UDC_OFF_INT_STATUS, 32'h1);
		rd(`UDC_OFF_INT_STATUS, v);
		chk(v[0], 1'b0, "iso flag clear");
		rd(`UDC_OFF_STATUS, v);
		chk(v[3:0], 4'h5, "iso endpoint");
	endtask
	task t_split;
		app_fifo_req <= 1'b1;
		usb_fifo_busy <= 1'b1;
		// Endpoint 0 space in both halves is left to software
		wr(`UDC_OFF_CONTROL, 32'h20);
		repeat (2) @(posedge clock);
		#1;
		chk({fifo_ram_half_split_q, app_fifo_stall_q}, 2'h2, "split");
		wr(`UDC_OFF_CONTROL, 32'h0);
		repeat (2) @(posedge clock);
		#1;
		chk(app_fifo_stall_q, 1'b1, "shared stall");
		app_fifo_req <= 1'b0;
	endtask
	task t_lock;
		wr(`UDC_OFF_CONTROL, 32'h2);
		prot_upd_req <= 1'b1;
		@(posedge clock);
		prot_upd_req <= 1'b0;
		cnt(0, n);
		chk(n, 0, "update while locked");
		wr(`UDC_OFF_CONTROL, 32'h0);
		cnt(0, n);
		chk(n, 1, "held update");
	endtask
	task t_desc;
		wr(`UDC_OFF_DRAM_CTRL, 32'h10);
		for (int i = 0; i < 3; i++) wr(`UDC_OFF_DRAM_DATA, 32'hA0 + i);
		module_enable <= 1'b1;
		wr(`UDC_OFF_DRAM_DATA, 32'hFF);
		rd(`UDC_OFF_DRAM_CTRL, v);
		chk(v[9:0], 10'h13, "address step");
		module_enable <= 1'b0;
		wr(`UDC_OFF_DRAM_CTRL, 32'h10);
		rd(`UDC_OFF_DRAM_DATA, v);
		chk(v, 32'hA0, "data read first");
		rd(`UDC_OFF_DRAM_DATA, v);
		chk(v, 32'hA1, "data read next");
		wr(`UDC_OFF_CONTROL, 32'h8);
		wr(`UDC_OFF_DRAM_DATA, 32'hEE);
		rd(`UDC_OFF_DRAM_CTRL, v);
		chk(v[9:0], 10'h12, "owner block");
		wr(`UDC_OFF_DRAM_CTRL, 32'h80030010);
		rd(`UDC_OFF_DRAM_CTRL, v);
		chk(v[31:30], 2'h1, "busy");
		chk(v[26:16], 11'h3, "length");
		for (n = 0; n < 40 && v[30] !== 1'b0; n++) rd(`UDC_OFF_DRAM_CTRL, v);
		chk(v[30], 1'b0, "idle");
		if (v[30] !== 1'b0)
			tally_and_finish;
		chk(host.cnt, 3, "byte count");
		for (int i = 0; i < 3; i++) chk(host.got[i], 8'hA0 + i, "byte");
	endtask
	task t_resume;
		wr(`UDC_OFF_CONTROL, 32'h1);
		// Bounded watch window stands in for the software wakeup timeout
		cnt(1, n);
		chk(n, 1, "resume pulse");
		rd(`UDC_OFF_CONTROL, v);
		chk(v[0], 1'b0, "resume clear");
		remote_wakeup_en <= 1'b0;
		repeat (4) @(posedge clock);
		wr(`UDC_OFF_CONTROL, 32'h1);
		cnt(1, n);
		chk(n, 0, "resume disabled");
	endtask
	task t_hrst;
		wr(`UDC_OFF_CONTROL, 32'h4);
		cnt(2, n);
		chk(n, 8, "hard reset");
	endtask

	initial
	begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		t_status;
		t_iso;
		t_split;
		t_lock;
		t_desc;
		t_resume;
		t_hrst;
		tally_and_finish;
	end
endmodule // usb_device_ctrl_status_descriptor_ram_tb_top

bind udc_ctrl_status udc_monitor u_mon (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .prot_upd_req(prot_upd_req),
	.prot_upd_go_q(prot_upd_go_q), .usb_fifo_busy(usb_fifo_busy), .app_fifo_req(app_fifo_req),
	.app_fifo_stall_q(app_fifo_stall_q), .fifo_ram_half_split_q(fifo_ram_half_split_q),
	.module_hard_reset_q(module_hard_reset_q), .resume_start_q(resume_start_q),
	.in_byte_ready(in_byte_ready), .in_byte_valid_q(in_byte_valid_q), .in_byte_q(in_byte_q));
